// >>> src/tcc_map.svh
`ifndef TCC_MAP_SVH
`define TCC_MAP_SVH

// ****************************************************************
// Register offsets on the plain register port
// ****************************************************************
`define TCC_ADDR_W 4
`define TCC_OFF_COUNT 4'h1
`define TCC_OFF_CMP_CTRL 4'h7
`define TCC_OFF_OPTION 4'hA
`define TCC_OFF_PORT_DIR 4'hB

// ****************************************************************
// Field positions
// ****************************************************************
`define TCC_OPT_CLK_SRC 5
`define TCC_OPT_EDGE_SEL 4
`define TCC_OPT_PSC_ASSIGN 3
`define TCC_OPT_RATIO_HI 2
`define TCC_OPT_RATIO_LO 0
`define TCC_CMC_RESULT 7
`define TCC_CMC_DRIVE_N 6
`define TCC_CMC_CLK_SEL 4
`define TCC_DIR_COUNT_PIN 2

// ****************************************************************
// Reset values
// ****************************************************************
`define TCC_RST_COUNT 8'h00
`define TCC_RST_PRESC 8'h00
`define TCC_RST_OPTION 8'hFF
`define TCC_RST_CMP_CTRL 7'h7F
`define TCC_RST_PORT_DIR 4'hF
// Edge detector idle level: edge select resets to falling, pin idles low
`define TCC_RST_SRC_LVL 1'b1

// ****************************************************************
// Timing
// ****************************************************************
`define TCC_CLK_PERIOD_NS 10
`define TCC_TOSC_NS 10
`define TCC_TOSC_CYC ((`TCC_TOSC_NS + `TCC_CLK_PERIOD_NS - 1) / `TCC_CLK_PERIOD_NS)
`define TCC_WR_INHIBIT 2'h2
`define TCC_INC_DLY_MIN_TOSC 3
`define TCC_INC_DLY_MAX_TOSC 7

`endif

// >>> src/tcc_pkg.sv
// ****************************************************************
// Types shared by the timer/counter files
// ****************************************************************
package tcc_pkg;

	// Instruction cycle phases, one oscillator period each
	typedef enum logic [1:0] {TCC_Q1, TCC_Q2, TCC_Q3, TCC_Q4} tcc_phase_t;

	// Two-stage synchroniser state
	typedef struct packed {
		logic [1:0] meta;
		logic [1:0] stable;
	} tcc_sync_t;

	// Whole state of the timer/counter
	typedef struct packed {
		tcc_phase_t phase;
		logic [7:0] count;
		logic [7:0] presc;
		logic [1:0] inhibit;
		logic samp;
		logic src_prev;
		logic [7:0] option;
		logic [6:0] cmp_ctrl;
		logic [3:0] port_dir;
		logic [7:0] rdata;
		logic pin_o;
		logic pin_oe;
		logic wd_post;
	} tcc_state_t;

endpackage : tcc_pkg

// >>> src/tcc_sync.sv
// ****************************************************************
// Two flip-flop synchroniser for the comparator and the count pin
// ****************************************************************
module tcc_sync (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [1:0] async_in,
	output logic [1:0] sync_out
);

	tcc_pkg::tcc_sync_t s_r;
	tcc_pkg::tcc_sync_t s_nxt;

	// First stage feeds only the second stage
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.meta = async_in;
		s_nxt.stable = s_r.meta;
	end

	// State register
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign sync_out = s_r.stable;

endmodule : tcc_sync

// >>> src/tcc_timer.sv
// Chosen here: the strobed register port.
`include "tcc_map.svh"

module tcc_timer (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic comparator_result,
	input wire logic count_pin_i,
	output logic count_pin_o,
	output logic count_pin_oe,
	input wire logic pin_latch,
	output logic [3:0] port_dir,
	input wire logic watchdog_tick,
	input wire logic watchdog_clear_instr,
	output logic watchdog_post_tick
);

	// ****************************************************************
	// Local timing figures
	// ****************************************************************
	localparam int TOSC_CYC = `TCC_TOSC_CYC;
	localparam int DLY_MIN = `TCC_INC_DLY_MIN_TOSC * TOSC_CYC;
	localparam int DLY_MAX = `TCC_INC_DLY_MAX_TOSC * TOSC_CYC;
	// The two sync stages use up the start of the update window
	localparam int SYNC_STAGES = 2;
	localparam int DLY_LO = DLY_MIN - SYNC_STAGES;
	localparam int DLY_HI = DLY_MAX - SYNC_STAGES;

	// ****************************************************************
	// Helper functions
	// ****************************************************************

	// Ratio field k taps bit k, a divide by two to the k plus one
	function automatic logic tcc_tap(input logic [7:0] p, input logic [2:0] k);
		tcc_tap = p[k];
	endfunction : tcc_tap

	// A low-to-high step between two samples
	function automatic logic tcc_rise(input logic now_lvl, input logic was_lvl);
		tcc_rise = now_lvl & ~was_lvl;
	endfunction : tcc_rise

	// ****************************************************************
	// State and synchronisers
	// ****************************************************************
	tcc_pkg::tcc_state_t s_r;
	tcc_pkg::tcc_state_t s_nxt;
	logic [1:0] sync_lvl;
	logic cmp_sync;
	logic pin_sync;

	// Comparator and pin both come from outside the clock domain
	tcc_sync i_tcc_sync (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.async_in({count_pin_i, comparator_result}),
		.sync_out(sync_lvl)
	);

	assign cmp_sync = sync_lvl[0];
	assign pin_sync = sync_lvl[1];

	// ****************************************************************
	// Decoded controls
	// ****************************************************************
	logic clk_src;
	logic edge_sel;
	logic psc_wd;
	logic [2:0] ratio;
	logic cmp_clk_sel;
	logic drive_n;
	logic wr_count;
	logic is_q2;
	logic is_q4;

	// Control bits and strobes used throughout
	always_comb
	begin
		clk_src = s_r.option[`TCC_OPT_CLK_SRC];
		edge_sel = s_r.option[`TCC_OPT_EDGE_SEL];
		psc_wd = s_r.option[`TCC_OPT_PSC_ASSIGN];
		ratio = s_r.option[`TCC_OPT_RATIO_HI:`TCC_OPT_RATIO_LO];
		cmp_clk_sel = s_r.cmp_ctrl[`TCC_CMC_CLK_SEL];
		drive_n = s_r.cmp_ctrl[`TCC_CMC_DRIVE_N];
		wr_count = reg_wr && (reg_addr == `TCC_OFF_COUNT);
		is_q2 = (s_r.phase == tcc_pkg::TCC_Q2);
		is_q4 = (s_r.phase == tcc_pkg::TCC_Q4);
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	logic src_raw;
	logic src_lvl;
	logic src_rise;
	logic presc_en;
	logic [7:0] presc_inc;
	logic tap_old;
	logic tap_new;
	logic pre_out;
	logic tick;

	// Source mux, prescaler, synchroniser and count update
	always_comb
	begin
		s_nxt = s_r;
		// Phase sequencer, one phase per oscillator period
		case (s_r.phase)
			tcc_pkg::TCC_Q1: s_nxt.phase = tcc_pkg::TCC_Q2;
			tcc_pkg::TCC_Q2: s_nxt.phase = tcc_pkg::TCC_Q3;
			tcc_pkg::TCC_Q3: s_nxt.phase = tcc_pkg::TCC_Q4;
			tcc_pkg::TCC_Q4: s_nxt.phase = tcc_pkg::TCC_Q1;
			default: s_nxt.phase = tcc_pkg::TCC_Q1;
		endcase

		// Pin when the comparator select is set, else the comparator
		src_raw = cmp_clk_sel ? pin_sync : cmp_sync;
		src_lvl = src_raw ^ edge_sel;
		src_rise = tcc_rise(src_lvl, s_r.src_prev);
		s_nxt.src_prev = src_lvl;

		// Prescaler input: watchdog ticks, source edges or cycles
		if (psc_wd)
			presc_en = watchdog_tick;
		else if (clk_src)
			presc_en = src_rise;
		else
			presc_en = is_q4;
		presc_inc = presc_en ? s_r.presc + 8'h01 : s_r.presc;
		tap_old = tcc_tap(s_r.presc, ratio);
		tap_new = tcc_tap(presc_inc, ratio);
		s_nxt.presc = presc_inc;

		// Timer tick from whichever clock applies
		tick = 1'b0;
		pre_out = psc_wd ? src_lvl : tap_old;
		if (!clk_src)
		begin
			// Instruction clock: every Q4 or each prescaler period
			tick = psc_wd ? is_q4 : (presc_en & tcc_rise(tap_new, tap_old));
		end
		else if (is_q2 || is_q4)
		begin
			// External clock sampled twice per instruction cycle
			s_nxt.samp = pre_out;
			tick = tcc_rise(pre_out, s_r.samp);
		end

		// Watchdog sees the prescaler as its postscaler
		s_nxt.wd_post = psc_wd & presc_en & tcc_rise(tap_new, tap_old);

		// Prescaler clears by its owner
		if (wr_count && !psc_wd)
			s_nxt.presc = `TCC_RST_PRESC;
		if (watchdog_clear_instr && psc_wd)
			s_nxt.presc = `TCC_RST_PRESC;

		// Count register: write, hold-off, then increment
		if (wr_count)
		begin
			s_nxt.count = reg_wdata;
			s_nxt.inhibit = `TCC_WR_INHIBIT;
		end
		else if (s_r.inhibit != 2'h0)
		begin
			if (is_q4)
				s_nxt.inhibit = s_r.inhibit - 2'h1;
		end
		else if (tick)
			s_nxt.count = s_r.count + 8'h01;

		// Control register writes
		if (reg_wr && (reg_addr == `TCC_OFF_OPTION))
			s_nxt.option = reg_wdata;
		if (reg_wr && (reg_addr == `TCC_OFF_CMP_CTRL))
			s_nxt.cmp_ctrl = reg_wdata[6:0];
		if (reg_wr && (reg_addr == `TCC_OFF_PORT_DIR))
			s_nxt.port_dir = reg_wdata[3:0];

		// Read data for the cycle after the strobe
		s_nxt.rdata = 8'h00;
		if (reg_rd)
		begin
			case (reg_addr)
				`TCC_OFF_COUNT: s_nxt.rdata = s_r.count;
				`TCC_OFF_CMP_CTRL: s_nxt.rdata = {cmp_sync, s_r.cmp_ctrl};
				default: s_nxt.rdata = 8'h00;
			endcase
		end

		// Shared count pin: comparator drive beats direction
		if (!drive_n)
		begin
			s_nxt.pin_oe = 1'b1;
			s_nxt.pin_o = cmp_sync;
		end
		else if (clk_src)
		begin
			s_nxt.pin_oe = 1'b0;
			s_nxt.pin_o = 1'b0;
		end
		else
		begin
			s_nxt.pin_oe = ~s_r.port_dir[`TCC_DIR_COUNT_PIN];
			s_nxt.pin_o = pin_latch;
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************

	// Reset gives zeroed counters and all-ones controls
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_r.phase <= tcc_pkg::TCC_Q1;
			s_r.count <= `TCC_RST_COUNT;
			s_r.presc <= `TCC_RST_PRESC;
			s_r.inhibit <= 2'h0;
			s_r.samp <= `TCC_RST_SRC_LVL;
			s_r.src_prev <= `TCC_RST_SRC_LVL;
			s_r.option <= `TCC_RST_OPTION;
			s_r.cmp_ctrl <= `TCC_RST_CMP_CTRL;
			s_r.port_dir <= `TCC_RST_PORT_DIR;
			s_r.rdata <= 8'h00;
			s_r.pin_o <= 1'b0;
			s_r.pin_oe <= 1'b0;
			s_r.wd_post <= 1'b0;
		end
		else
			s_r <= s_nxt;
	end

	// Outputs straight from the state register
	assign reg_rdata = s_r.rdata;
	assign count_pin_o = s_r.pin_o;
	assign count_pin_oe = s_r.pin_oe;
	assign port_dir = s_r.port_dir;
	assign watchdog_post_tick = s_r.wd_post;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking chk_cb @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);

	// Written value appears in the count
	chk_count_write_load: assert property (wr_count |=> s_r.count == $past(reg_wdata))
		else $error("count did not take written value");

	// Count readback is a one-cycle answer
	chk_count_read_latency: assert property (
		reg_rd && reg_addr == `TCC_OFF_COUNT |=> reg_rdata == $past(s_r.count))
		else $error("count read data wrong");

	// No increment while the hold-off runs
	chk_inhibit_holds_count: assert property (
		s_r.inhibit != 2'h0 && !wr_count |=> s_r.count == $past(s_r.count))
		else $error("count moved during write hold-off");

	// Hold-off lasts exactly two Q4 phases from a write
	chk_inhibit_two_cycles: assert property (
		wr_count ##1 (!wr_count)[*8] |=> s_r.inhibit == 2'h0)
		else $error("hold-off did not expire");

	// Unscaled timer mode steps once per instruction cycle
	chk_timer_mode_step: assert property (
		!clk_src && psc_wd && is_q4 && s_r.inhibit == 2'h0 && !wr_count
		|=> s_r.count == $past(s_r.count) + 8'h01)
		else $error("timer mode missed an increment");

	// Timer-owned prescaler cleared by a count write
	chk_presc_write_clear: assert property (wr_count && !psc_wd |=> s_r.presc == 8'h00)
		else $error("prescaler not cleared by count write");

	// Watchdog-owned prescaler cleared by its clear
	chk_presc_wd_clear: assert property (
		watchdog_clear_instr && psc_wd |=> s_r.presc == 8'h00)
		else $error("prescaler not cleared by watchdog clear");

	// Watchdog-owned prescaler ignores timer sources
	chk_presc_owner_excl: assert property (
		psc_wd && !watchdog_tick && !watchdog_clear_instr |=> $stable(s_r.presc))
		else $error("prescaler moved without watchdog tick");

	// Counter mode releases the pin unless the comparator drives it
	chk_dir_override: assert property (clk_src && drive_n |=> !count_pin_oe)
		else $error("count pin driven in counter mode");

	// Comparator result placed on the pin when drive bit clear
	chk_cmp_pin_drive: assert property (
		!drive_n |=> count_pin_oe && count_pin_o == $past(cmp_sync))
		else $error("comparator not driven on pin");

	// Pin edge reaches the count within the allowed delay
	chk_ext_inc_delay: assert property (
		clk_src && cmp_clk_sel && drive_n && !edge_sel && psc_wd && s_r.inhibit == 2'h0
		&& !reg_wr && $rose(pin_sync)
		|-> ##[DLY_LO:DLY_HI] s_r.count != $past(s_r.count))
		else $error("pin edge not counted in time");

	// Between writes the count moves by at most one step
	chk_count_single_step: assert property (!wr_count |=>
		s_r.count == $past(s_r.count) || s_r.count == $past(s_r.count) + 8'h01)
		else $error("count jumped by more than one");

	// Main scenarios
	cov_timer_wrap: cover property (s_r.count == 8'hFF ##1 s_r.count == 8'h00);
	cov_pin_count: cover property (clk_src && cmp_clk_sel && drive_n && tick);
	cov_cmp_count: cover property (clk_src && !cmp_clk_sel && tick);
	cov_scaled_tick: cover property (!psc_wd && ratio == 3'h7 && tick);

endmodule : tcc_timer

// >>> dv/tcc_src_model.sv
// ****************************************************************
// Far-side pulse source and comparator model
// ****************************************************************
module tcc_src_model (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic pulse_req,
	input wire logic use_cmp,
	input wire logic count_pin_o,
	input wire logic count_pin_oe,
	output logic comparator_result,
	output logic count_pin_i,
	output logic busy
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] cnt_r;
	logic lvl_r;
	logic sel_r;
	// One pulse per request: high three clocks, then low at least three
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt_r <= 3'h0;
			lvl_r <= 1'b0;
			sel_r <= 1'b0;
		end
		else if (cnt_r == 3'h0 && pulse_req)
		begin
			cnt_r <= 3'h6;
			lvl_r <= 1'b1;
			sel_r <= use_cmp;
		end
		else if (cnt_r != 3'h0)
		begin
			cnt_r <= cnt_r - 3'h1;
			lvl_r <= (cnt_r > 3'h4);
		end
	end
	// Pin wire: device drive wins, else the external source
	assign count_pin_i = count_pin_oe ? count_pin_o : (lvl_r & ~sel_r);
	assign comparator_result = lvl_r & sel_r;
	assign busy = (cnt_r != 3'h0);
endmodule : tcc_src_model

// >>> dv/test_timer_counter_with_comparator_clock.sv
`include "tcc_map.svh"
`define CHK(nm, e, g) \
	begin \
		cmp_count++; \
		if ((g) !== (e)) \
		begin \
			failures++; \
			$display("[FAIL] %s exp %h got %h", nm, e, g); \
		end \
	end
// ****************************************************************
// Timer/counter bench
// ****************************************************************
module test_timer_counter_with_comparator_clock;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic pin_latch = 1'b0;
	logic watchdog_tick = 1'b0;
	logic watchdog_clear_instr = 1'b0;
	logic pulse_req = 1'b0;
	logic use_cmp = 1'b0;
	logic [7:0] reg_rdata, a, b;
	logic [3:0] port_dir;
	logic comparator_result, count_pin_i, count_pin_o, count_pin_oe;
	logic watchdog_post_tick, busy;
	int failures = 0;
	int cmp_count = 0;
	int post_seen = 0;
	logic [7:0] ctl [5] = '{8'h7F, 8'h7F, 8'h6F, 8'h2F, 8'h3F};
	logic [7:0] exp_n [5] = '{8'h02, 8'h00, 8'h02, 8'h02, 8'h02};
	logic [4:0] cm = 5'b11110;

	tcc_timer i_tcc_timer (.sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .comparator_result, .count_pin_i, .count_pin_o, .count_pin_oe,
		.pin_latch, .port_dir, .watchdog_tick, .watchdog_clear_instr, .watchdog_post_tick);
	tcc_src_model i_tcc_src_model (.sys_clk, .arst_n, .pulse_req, .use_cmp,
		.count_pin_o, .count_pin_oe, .comparator_result, .count_pin_i, .busy);

	// Clock and postscaler pulse count
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
		if (watchdog_post_tick === 1'b1)
			post_seen++;

	// ****************************************************************
	// Bus and stimulus tasks
	// ****************************************************************
	task automatic wr(input logic [3:0] ad, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] ad, output logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		d = reg_rdata;
	endtask : rd
	task automatic test_done();
		$display("Compares %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : test_done
	task automatic pulse(input logic c);
		int n;
		@(posedge sys_clk);
		pulse_req <= 1'b1;
		use_cmp <= c;
		@(posedge sys_clk);
		pulse_req <= 1'b0;
		n = 0;
		@(negedge sys_clk);
		while (busy === 1'b1 && n < 20)
		begin
			@(negedge sys_clk);
			n++;
		end
		if (n >= 20)
		begin
			failures++;
			test_done();
		end
		repeat (8) @(posedge sys_clk);
	endtask : pulse
	task automatic wd(input logic clr);
		@(posedge sys_clk);
		watchdog_tick <= ~clr;
		watchdog_clear_instr <= clr;
		@(posedge sys_clk);
		watchdog_tick <= 1'b0;
		watchdog_clear_instr <= 1'b0;
	endtask : wd

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset();
		rd(`TCC_OFF_COUNT, a); `CHK("count", 8'h00, a)
		rd(`TCC_OFF_CMP_CTRL, a); `CHK("ctrl", 8'h7F, a)
		rd(`TCC_OFF_OPTION, a); `CHK("option", 8'h00, a)
		rd(4'h3, a); `CHK("unmapped", 8'h00, a)
		`CHK("dir", 4'hF, port_dir)
		`CHK("oe", 1'b0, count_pin_oe)
		wr(`TCC_OFF_CMP_CTRL, 8'hFF);
		rd(`TCC_OFF_CMP_CTRL, a); `CHK("ctrl ro", 8'h7F, a)
		wr(`TCC_OFF_COUNT, 8'h5A);
		rd(`TCC_OFF_COUNT, a); `CHK("count rw", 8'h5A, a)
		$display("reset test done");
	endtask : t_reset
	task automatic t_timer();
		wr(`TCC_OFF_OPTION, 8'h08);
		wr(`TCC_OFF_COUNT, 8'hFE);
		repeat (4) @(posedge sys_clk);
		rd(`TCC_OFF_COUNT, a); `CHK("hold", 8'hFE, a)
		repeat (12) @(posedge sys_clk);
		rd(`TCC_OFF_COUNT, a); `CHK("wrap", 1'b1, a < 8'h03)
		repeat (38) @(posedge sys_clk);
		rd(`TCC_OFF_COUNT, b); `CHK("rate", 8'h0A, 8'(b - a))
		$display("timer test done");
	endtask : t_timer
	task automatic t_presc();
		for (int ps = 0; ps < 8; ps++)
		begin
			wr(`TCC_OFF_OPTION, {5'h00, 3'(ps)});
			wr(`TCC_OFF_COUNT, 8'h00);
			repeat (12) @(posedge sys_clk);
			rd(`TCC_OFF_COUNT, a);
			repeat ((8 << (ps + 1)) - 2) @(posedge sys_clk);
			rd(`TCC_OFF_COUNT, b); `CHK("ratio", 8'h02, 8'(b - a))
		end
		$display("prescale test done");
	endtask : t_presc
	task automatic t_watchdog();
		wd(1'b1);
		wr(`TCC_OFF_COUNT, 8'h00);
		wr(`TCC_OFF_OPTION, 8'h2F);
		wd(1'b1);
		wr(`TCC_OFF_OPTION, 8'h29);
		post_seen = 0;
		repeat (8) wd(1'b0);
		repeat (3) @(posedge sys_clk);
		`CHK("post 1:4", 2, post_seen)
		repeat (3) wd(1'b0);
		wd(1'b1);
		repeat (2) wd(1'b0);
		repeat (3) @(posedge sys_clk);
		`CHK("post clr", 4, post_seen)
		repeat (4) wd(1'b0);
		repeat (3) @(posedge sys_clk);
		`CHK("post next", 5, post_seen)
		wd(1'b1);
		$display("watchdog test done");
	endtask : t_watchdog
	task automatic t_delay();
		for (int f = 0; f < 2; f++)
		begin
			wr(`TCC_OFF_OPTION, f ? 8'h38 : 8'h28);
			wr(`TCC_OFF_COUNT, 8'h00);
			repeat (12) @(posedge sys_clk);
			@(posedge sys_clk);
			pulse_req <= 1'b1;
			use_cmp <= 1'b0;
			@(posedge sys_clk);
			pulse_req <= 1'b0;
			rd(`TCC_OFF_COUNT, a); `CHK("early", 8'h00, a)
			@(posedge sys_clk);
			rd(`TCC_OFF_COUNT, a); `CHK("edge", 8'(1 - f), a)
			repeat (12) @(posedge sys_clk);
			rd(`TCC_OFF_COUNT, a); `CHK("after", 8'h01, a)
		end
		$display("edge test done");
	endtask : t_delay
	task automatic t_modes();
		wr(`TCC_OFF_OPTION, 8'h28);
		for (int i = 0; i < 5; i++)
		begin
			wr(`TCC_OFF_CMP_CTRL, ctl[i]);
			wr(`TCC_OFF_COUNT, 8'h00);
			repeat (12) @(posedge sys_clk);
			pulse(cm[i]);
			pulse(cm[i]);
			rd(`TCC_OFF_COUNT, a); `CHK("mode", exp_n[i], a)
			`CHK("pin oe", ~ctl[i][6], count_pin_oe)
		end
		wr(`TCC_OFF_CMP_CTRL, 8'h7F);
		$display("source test done");
	endtask : t_modes
	task automatic t_ext_presc();
		wr(`TCC_OFF_OPTION, 8'h20);
		wr(`TCC_OFF_COUNT, 8'h00);
		repeat (12) @(posedge sys_clk);
		repeat (4) pulse(1'b0);
		rd(`TCC_OFF_COUNT, a); `CHK("ext 1:2", 8'h02, a)
		wr(`TCC_OFF_COUNT, 8'h00);
		repeat (12) @(posedge sys_clk);
		pulse(1'b0);
		wr(`TCC_OFF_COUNT, 8'h00);
		repeat (12) @(posedge sys_clk);
		pulse(1'b0);
		rd(`TCC_OFF_COUNT, a); `CHK("presc clr", 8'h01, a)
		$display("ext prescale test done");
	endtask : t_ext_presc
	task automatic t_pin();
		wr(`TCC_OFF_OPTION, 8'h08);
		wr(`TCC_OFF_PORT_DIR, 8'h00);
		pin_latch <= 1'b1;
		repeat (3) @(posedge sys_clk);
		`CHK("dir", 4'h0, port_dir)
		`CHK("oe out", 1'b1, count_pin_oe)
		`CHK("latch", 1'b1, count_pin_o)
		wr(`TCC_OFF_OPTION, 8'h28);
		repeat (3) @(posedge sys_clk);
		`CHK("oe over", 1'b0, count_pin_oe)
		$display("pin test done");
	endtask : t_pin

	// Main sequence
	initial
	begin
		repeat (4) @(posedge sys_clk);
		arst_n <= 1'b1;
		t_reset();
		t_timer();
		t_presc();
		t_watchdog();
		t_delay();
		t_modes();
		t_ext_presc();
		t_pin();
		test_done();
	end
endmodule : test_timer_counter_with_comparator_clock
